// ==== verilog/plm_core.sv ====
// run/stop, auto/manual, heat/cool split, remote/local and power-on fault handling
`timescale 1ns/100ps
`include "plm_defines.svh"
module plm_core #(
  parameter int REPEAT_CYC = `PLM_REPEAT_MS * `PLM_CLK_KHZ,
  parameter int BLINK_CYC  = `PLM_BLINK_MS * `PLM_CLK_KHZ
) (
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  input  wire logic [`PLM_ADDR_W-1:0]  addr,
  input  wire logic [15:0]             wdata,
  input  wire logic                    wr,
  input  wire logic                    rd,
  output logic      [15:0]             rdata,
  input  wire logic                    run_stop_contact,
  input  wire logic                    mode_force_contact,
  input  wire logic                    mode_level_contact,
  input  wire logic                    remote_force_contact,
  input  wire logic                    mode_toggle_key,
  input  wire logic                    up_key,
  input  wire logic                    down_key,
  input  wire logic                    remote_toggle_key,
  input  wire logic [15:0]             measured_process_value,
  input  wire logic [15:0]             remote_setpoint_in,
  input  wire logic signed [10:0]      auto_mv,
  input  wire logic                    alarm_condition,
  input  wire logic                    selfcheck_valid,
  input  wire logic                    selfcheck_ram_fail,
  input  wire logic                    selfcheck_rom_fail,
  input  wire logic                    selfcheck_sys_fail,
  input  wire logic                    selfcheck_cal_fail,
  input  wire logic [6:0]              selfcheck_param_flags,
  output logic      [9:0]              control_out,
  output logic      [9:0]              heat_out,
  output logic      [9:0]              cool_out,
  output logic                         actuator_open,
  output logic                         actuator_close,
  output logic                         alarm_out,
  output logic      [15:0]             pv_display,
  output logic                         pv_point_on,
  output logic      [15:0]             target_setpoint,
  output logic      [1:0]              pid_group,
  output logic                         running,
  output logic                         manual_operation,
  output logic                         remote_setpoint_mode,
  output logic                         comm_enable,
  output plm_pkg::plm_fault_type       fault_kind,
  output logic      [3:0]              fault_tens,
  output logic      [3:0]              fault_ones
);
  import plm_pkg::*;

  logic [`PLM_IN_W-1:0] pin_s;
  logic [`PLM_IN_W-1:0] pin_d_r;
  logic                 toggle_edge;
  logic                 rl_key_edge;
  logic                 up_s;
  logic                 dn_s;
  logic                 step_tick;
  logic                 blink_tick;
  logic                 blink_r;

  logic                 hc_en_r;
  logic                 pp_en_r;
  logic                 fitted_r;
  logic [1:0]           sp_idx_r;
  logic [9:0]           preset_r;
  logic signed [10:0]   band_r;
  logic [7:0]           step_r;
  logic [15:0]          local_sp_r [4];

  logic                 mem_fault_r;
  logic                 cal_fault_r;
  logic [1:0]           mem_code_r;
  logic [6:0]           param_flags_r;
  logic                 force_min;

  logic signed [10:0]   mv_r;
  logic signed [10:0]   mv_lo;
  logic signed [11:0]   mv_step;
  logic signed [11:0]   overlap;
  logic                 adjusting;

  // lower bound of the manipulated value: heat/cool spans both signs
  function automatic logic signed [10:0] clamp_mv(input logic signed [11:0] v,
                                                   input logic signed [10:0] lo);
    if (v > 12'(`PLM_OUT_MAX)) begin
      return `PLM_OUT_MAX;
    end else if (v < 12'(lo)) begin
      return lo;
    end else begin
      return v[10:0];
    end
  endfunction

  function automatic logic [9:0] to_out(input logic signed [11:0] v);
    logic signed [11:0] c;
    c = v;
    if (c < 12'sh000) begin
      c = 12'sh000;
    end else if (c > 12'(`PLM_OUT_MAX)) begin
      c = 12'(`PLM_OUT_MAX);
    end
    return c[9:0];
  endfunction

  plm_sync #(
    .W (`PLM_IN_W)
  ) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .din   ({remote_toggle_key, down_key, up_key, mode_toggle_key,
             remote_force_contact, mode_level_contact, mode_force_contact,
             run_stop_contact}),
    .dout  (pin_s)
  );

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_d_r <= '0;
    end else begin
      pin_d_r <= pin_s;
    end
  end

  assign toggle_edge = pin_s[`PLM_IN_MKEY] & ~pin_d_r[`PLM_IN_MKEY];
  assign rl_key_edge = pin_s[`PLM_IN_RLKEY] & ~pin_d_r[`PLM_IN_RLKEY];
  // both keys at once is treated as neither
  assign up_s        = pin_s[`PLM_IN_UP] & ~pin_s[`PLM_IN_DN];
  assign dn_s        = pin_s[`PLM_IN_DN] & ~pin_s[`PLM_IN_UP];
  assign adjusting   = manual_operation & running & ~force_min & (up_s | dn_s);

  plm_tick #(
    .PERIOD (REPEAT_CYC)
  ) u_repeat (
    .mclk  (mclk),
    .rst_n (rst_n),
    .en    (adjusting),
    .tick  (step_tick)
  );

  plm_tick #(
    .PERIOD (BLINK_CYC)
  ) u_blink (
    .mclk  (mclk),
    .rst_n (rst_n),
    .en    (cal_fault_r),
    .tick  (blink_tick)
  );

  // register writes
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hc_en_r  <= 1'b0;
      pp_en_r  <= 1'b0;
      fitted_r <= 1'b0;
      sp_idx_r <= 2'h0;
      preset_r <= `PLM_PRESET_RST;
      band_r   <= `PLM_BAND_RST;
      step_r   <= `PLM_STEP_RST;
      for (int i = 0; i < 4; i++) begin
        local_sp_r[i] <= `PLM_SP_RST;
      end
    end else if (wr) begin
      if (addr == `PLM_REG_CTRL) begin
        hc_en_r  <= wdata[`PLM_CTRL_HC];
        pp_en_r  <= wdata[`PLM_CTRL_PP];
        fitted_r <= wdata[`PLM_CTRL_FIT];
        sp_idx_r <= wdata[`PLM_CTRL_IDX_LO +: 2];
      end else if (addr == `PLM_REG_PRESET) begin
        preset_r <= wdata[9:0];
      end else if (addr == `PLM_REG_DEADBAND) begin
        band_r <= wdata[10:0];
      end else if (addr == `PLM_REG_STEP) begin
        step_r <= wdata[7:0];
      end else if (addr[3:2] == `PLM_REG_SP0 >> 2) begin
        local_sp_r[addr[1:0]] <= wdata;
      end
    end
  end

  // register reads, data in the following cycle only
  always_ff @(posedge mclk) begin
    if (!rst_n || !rd) begin
      rdata <= 16'h0000;
    end else if (addr == `PLM_REG_CTRL) begin
      rdata <= {10'h000, sp_idx_r, 1'b0, fitted_r, pp_en_r, hc_en_r};
    end else if (addr == `PLM_REG_PRESET) begin
      rdata <= {6'h00, preset_r};
    end else if (addr == `PLM_REG_DEADBAND) begin
      rdata <= {{5{band_r[10]}}, band_r};
    end else if (addr == `PLM_REG_STEP) begin
      rdata <= {8'h00, step_r};
    end else if (addr[3:2] == `PLM_REG_SP0 >> 2) begin
      rdata <= local_sp_r[addr[1:0]];
    end else if (addr == `PLM_REG_STATUS) begin
      rdata <= {mv_r[10], 10'h000, ~mv_r[10], remote_setpoint_mode,
                manual_operation, running, comm_enable};
    end else if (addr == `PLM_REG_DIAG) begin
      rdata <= {5'h00, mem_code_r, mem_fault_r, cal_fault_r, param_flags_r};
    end else begin
      rdata <= 16'h0000;
    end
  end

  // power-on diagnosis result, latched each time the self-check reports
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mem_fault_r   <= 1'b0;
      cal_fault_r   <= 1'b0;
      mem_code_r    <= `PLM_FAULT_RAM;
      param_flags_r <= 7'h00;
    end else if (selfcheck_valid) begin
      mem_fault_r   <= selfcheck_ram_fail | selfcheck_rom_fail | selfcheck_sys_fail;
      cal_fault_r   <= selfcheck_cal_fail;
      param_flags_r <= selfcheck_param_flags;
      if (selfcheck_ram_fail) begin
        mem_code_r <= `PLM_FAULT_RAM;
      end else if (selfcheck_rom_fail) begin
        mem_code_r <= `PLM_FAULT_ROM;
      end else begin
        mem_code_r <= `PLM_FAULT_SYS;
      end
    end
  end

  assign force_min = mem_fault_r | (|param_flags_r);

  // fault display: memory faults win over parameter faults
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fault_kind  <= plm_fk_none;
      fault_tens  <= 4'h0;
      fault_ones  <= 4'h0;
      comm_enable <= 1'b1;
    end else begin
      comm_enable <= ~mem_fault_r;
      if (mem_fault_r) begin
        fault_kind <= plm_fk_sys;
        fault_tens <= 4'h0;
        fault_ones <= {2'h0, mem_code_r};
      end else if (|param_flags_r) begin
        // flags above 99 show a tens digit of 10 to 12
        fault_kind <= plm_fk_param;
        fault_tens <= 4'(param_flags_r / 7'd10);
        fault_ones <= 4'(param_flags_r % 7'd10);
      end else begin
        fault_kind <= plm_fk_none;
        fault_tens <= 4'h0;
        fault_ones <= 4'h0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n || !cal_fault_r) begin
      blink_r <= 1'b0;
    end else if (blink_tick) begin
      blink_r <= ~blink_r;
    end
  end

  // display and alarm stay live in stop
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pv_display  <= 16'h0000;
      pv_point_on <= 1'b1;
      alarm_out   <= 1'b0;
    end else begin
      pv_display  <= measured_process_value;
      pv_point_on <= ~blink_r;
      alarm_out   <= alarm_condition & ~mem_fault_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      running <= 1'b0;
    end else begin
      running <= pin_s[`PLM_IN_RUN];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      manual_operation <= 1'b0;
    end else if (pin_s[`PLM_IN_MFORCE]) begin
      manual_operation <= pin_s[`PLM_IN_MLEVEL];
    end else if (toggle_edge) begin
      manual_operation <= ~manual_operation;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n || !fitted_r) begin
      remote_setpoint_mode <= 1'b0;
    end else if (pin_s[`PLM_IN_RFORCE]) begin
      remote_setpoint_mode <= 1'b1;
    end else if (rl_key_edge) begin
      remote_setpoint_mode <= ~remote_setpoint_mode;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      target_setpoint <= `PLM_SP_RST;
      pid_group       <= 2'h0;
    end else begin
      target_setpoint <= remote_setpoint_mode ? remote_setpoint_in
                                              : local_sp_r[sp_idx_r];
      pid_group       <= sp_idx_r;
    end
  end

  // manipulated value: tracks auto for a bumpless switch, stepped in manual
  assign mv_lo   = hc_en_r ? -`PLM_OUT_MAX : `PLM_OUT_MIN;
  assign mv_step = dn_s ? 12'(mv_r) - 12'(step_r) : 12'(mv_r) + 12'(step_r);
  assign overlap = hc_en_r && band_r < 11'sh000 ? -(12'(band_r) <<< 1) : 12'sh000;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mv_r <= `PLM_OUT_MIN;
    end else if (!manual_operation) begin
      mv_r <= clamp_mv(12'(auto_mv), mv_lo);
    end else if (step_tick && adjusting && !pp_en_r) begin
      mv_r <= clamp_mv(mv_step, mv_lo);
    end
  end

  // output stage; stop preset overrides manual steps, memory and parameter faults override all
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      control_out <= 10'h000;
      heat_out    <= 10'h000;
      cool_out    <= 10'h000;
    end else if (force_min) begin
      control_out <= 10'h000;
      heat_out    <= 10'h000;
      cool_out    <= 10'h000;
    end else if (!running) begin
      control_out <= preset_r;
      heat_out    <= preset_r;
      cool_out    <= 10'h000;
    end else if (!hc_en_r) begin
      control_out <= to_out(12'(mv_r));
      heat_out    <= 10'h000;
      cool_out    <= 10'h000;
    end else if (overlap == 12'sh000) begin
      // positive band: sign of the value picks the side, both zero at zero
      control_out <= to_out(12'(mv_r));
      heat_out    <= to_out(12'(mv_r));
      cool_out    <= to_out(-12'(mv_r));
    end else begin
      // negative band: cooling rises as heating falls under the overlap
      control_out <= to_out(12'(mv_r));
      heat_out    <= to_out(12'(mv_r));
      cool_out    <= to_out(overlap - 12'(mv_r));
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      actuator_open  <= 1'b0;
      actuator_close <= 1'b0;
    end else begin
      actuator_open  <= pp_en_r & adjusting & up_s;
      actuator_close <= pp_en_r & adjusting & dn_s;
    end
  end
endmodule

// ==== verilog/plm_defines.svh ====
// constants for the process loop mode control block
`ifndef PLM_DEFINES_SVH
`define PLM_DEFINES_SVH

`define PLM_ADDR_W        4
`define PLM_REG_CTRL      4'h0
`define PLM_REG_PRESET    4'h1
`define PLM_REG_DEADBAND  4'h2
`define PLM_REG_STEP      4'h3
`define PLM_REG_SP0       4'h4
`define PLM_REG_STATUS    4'h8
`define PLM_REG_DIAG      4'h9

`define PLM_CTRL_HC       0
`define PLM_CTRL_PP       1
`define PLM_CTRL_FIT      2
`define PLM_CTRL_IDX_LO   4

`define PLM_OUT_MAX       11'sh3e8
`define PLM_OUT_MIN       11'sh000
`define PLM_PRESET_RST    10'h000
`define PLM_BAND_RST      11'sh000
`define PLM_STEP_RST      8'h01
`define PLM_SP_RST        16'h0000

`define PLM_CLK_KHZ       100000
`define PLM_REPEAT_MS     100
`define PLM_BLINK_MS      500

`define PLM_IN_RUN        0
`define PLM_IN_MFORCE     1
`define PLM_IN_MLEVEL     2
`define PLM_IN_RFORCE     3
`define PLM_IN_MKEY       4
`define PLM_IN_UP         5
`define PLM_IN_DN         6
`define PLM_IN_RLKEY      7
`define PLM_IN_W          8

`define PLM_FAULT_RAM     2'h0
`define PLM_FAULT_ROM     2'h1
`define PLM_FAULT_SYS     2'h2

`endif

// ==== verilog/plm_pkg.sv ====
// types shared by the process loop mode control block
package plm_pkg;
  typedef enum logic [1:0] {
    plm_fk_none,
    plm_fk_sys,
    plm_fk_param
  } plm_fault_type;
endpackage

// ==== verilog/plm_sync.sv ====
// three-stage synchroniser; a change counts once stages two and three agree
`timescale 1ns/100ps
module plm_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // per bit: a glitch seen by only one stage is not passed on
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dout <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          dout[i] <= s3_r[i];
        end
      end
    end
  end
endmodule

// ==== verilog/plm_tick.sv ====
// periodic tick generator, first tick in the cycle after the first enabled cycle
`timescale 1ns/100ps
module plm_tick #(
  parameter int PERIOD = 10
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic en,
  output logic      tick
);
  logic [31:0] cnt_r;

  always_ff @(posedge mclk) begin
    if (!rst_n || !en) begin
      cnt_r <= 32'h0;
      tick  <= 1'b0;
    end else begin
      tick  <= (cnt_r == 32'h0);
      cnt_r <= (cnt_r == 32'(PERIOD - 1)) ? 32'h0 : cnt_r + 32'h1;
    end
  end
endmodule

// ==== test/plm_core_asserts.sv ====
// concurrent checks on the ports of the process loop mode control block
`timescale 1ns/100ps
`include "plm_defines.svh"
module plm_core_asserts (
  input wire logic                   mclk,
  input wire logic                   rst_n,
  input wire logic [`PLM_ADDR_W-1:0] addr,
  input wire logic [15:0]            wdata,
  input wire logic                   wr,
  input wire logic                   mode_force_contact,
  input wire logic                   mode_level_contact,
  input wire logic                   remote_force_contact,
  input wire logic                   mode_toggle_key,
  input wire logic                   up_key,
  input wire logic                   down_key,
  input wire logic                   alarm_condition,
  input wire logic                   selfcheck_valid,
  input wire logic [6:0]             selfcheck_param_flags,
  input wire logic [9:0]             control_out,
  input wire logic [9:0]             cool_out,
  input wire logic                   actuator_open,
  input wire logic                   actuator_close,
  input wire logic                   alarm_out,
  input wire logic [1:0]             pid_group,
  input wire logic                   running,
  input wire logic                   manual_operation,
  input wire logic                   remote_setpoint_mode,
  input wire logic                   comm_enable,
  input wire plm_pkg::plm_fault_type fault_kind,
  input wire logic [3:0]             fault_tens,
  input wire logic [3:0]             fault_ones
);
  import plm_pkg::*;
  logic [9:0] preset_r;
  logic [1:0] idx_r;
  logic       fitted_r;
  logic [6:0] flags_r;
  logic [7:0] code;
  assign code = 8'(fault_tens) * 8'h0a + 8'(fault_ones);
  // mirror of the config registers, updated on the same edge as the design's
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      preset_r <= `PLM_PRESET_RST;
      idx_r    <= 2'h0;
      fitted_r <= 1'b0;
    end else if (wr && addr == `PLM_REG_PRESET) begin
      preset_r <= wdata[9:0];
    end else if (wr && addr == `PLM_REG_CTRL) begin
      idx_r    <= wdata[5:4];
      fitted_r <= wdata[`PLM_CTRL_FIT];
    end
  end
  // flag word is latched at each self-check report and cleared by reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      flags_r <= 7'h00;
    end else if (selfcheck_valid) begin
      flags_r <= selfcheck_param_flags;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  stop_preset_a: assert property (
    (!running && fault_kind == plm_fk_none && $stable(preset_r))[*4]
    |-> control_out == preset_r && cool_out == 10'h000)
    else $error("stopped output is not the preset");
  alarm_live_a: assert property (
    comm_enable && $past(comm_enable) && $past(rst_n) |-> alarm_out == $past(alarm_condition))
    else $error("alarm output does not follow the alarm condition");
  toggle_flip_a: assert property (
    $rose(mode_toggle_key) && !mode_force_contact |-> ##[2:8] $changed(manual_operation))
    else $error("mode key press did not flip auto and manual");
  mode_force_a: assert property (
    (mode_force_contact && $stable(mode_level_contact))[*8]
    |-> manual_operation == mode_level_contact)
    else $error("forced auto or manual not kept");
  open_drive_a: assert property (
    !up_key[*8] |-> !actuator_open)
    else $error("actuator opens with no key held");
  close_drive_a: assert property (
    !down_key[*8] |-> !actuator_close)
    else $error("actuator closes with no key held");
  remote_force_a: assert property (
    (remote_force_contact && fitted_r)[*8] |-> remote_setpoint_mode)
    else $error("forced remote not kept");
  pid_group_a: assert property (
    $stable(idx_r)[*3] |-> pid_group == idx_r)
    else $error("tuning group differs from setpoint index");
  param_fault_a: assert property (
    fault_kind == plm_fk_param && $past(fault_kind) == plm_fk_param
    |-> control_out == 10'h000 && comm_enable && code == {1'b0, flags_r})
    else $error("parameter fault handling wrong");
  sys_fault_a: assert property (
    fault_kind == plm_fk_sys && $past(fault_kind) == plm_fk_sys
    |-> !comm_enable && control_out == 10'h000 && !alarm_out)
    else $error("memory fault handling wrong");
endmodule

bind plm_core plm_core_asserts chk_u (
  .mclk, .rst_n, .addr, .wdata, .wr, .mode_force_contact, .mode_level_contact,
  .remote_force_contact, .mode_toggle_key, .up_key, .down_key, .alarm_condition,
  .selfcheck_valid, .selfcheck_param_flags, .control_out, .cool_out, .actuator_open,
  .actuator_close, .alarm_out, .pid_group, .running, .manual_operation,
  .remote_setpoint_mode, .comm_enable, .fault_kind, .fault_tens, .fault_ones
);

// ==== test/plm_panel.sv ====
// front panel, contact inputs and a valve travel counter
`timescale 1ns/100ps
module plm_panel (
  input  wire logic   mclk,
  input  wire logic   actuator_close,
  output logic        run_stop_contact,
  output logic        mode_force_contact,
  output logic        mode_level_contact,
  output logic        remote_force_contact,
  output logic        mode_toggle_key,
  output logic        up_key,
  output logic        down_key,
  output logic        remote_toggle_key,
  output logic [15:0] close_cycles
);
  logic [3:0] keys;
  logic [3:0] contacts;
  assign {remote_toggle_key, down_key, up_key, mode_toggle_key} = keys;
  assign {remote_force_contact, mode_level_contact,
          mode_force_contact, run_stop_contact} = contacts;
  initial begin
    keys = 4'h0;
    contacts = 4'h0;
    close_cycles = 16'h0000;
  end
  // only closing time is counted, enough to judge a jog's length
  always @(posedge mclk) begin
    if (actuator_close) begin
      close_cycles <= close_cycles + 16'h0001;
    end
  end
  task automatic hold(input int k, input logic on);
    @(posedge mclk);
    keys <= on ? (4'h1 << k) : 4'h0;
  endtask
  // a released gap follows every press, else two presses merge
  task automatic press(input int k, input int n);
    hold(k, 1'b1);
    repeat (n) @(posedge mclk);
    keys <= 4'h0;
    repeat (8) @(posedge mclk);
    #1;
  endtask
  task automatic set_contacts(input logic [3:0] c);
    @(posedge mclk);
    contacts <= c;
    repeat (8) @(posedge mclk);
    #1;
  endtask
endmodule

// ==== test/plm_core_bench.sv ====
// self-checking bench for the process loop mode control block
`timescale 1ns/100ps
`include "plm_defines.svh"
module plm_core_bench;
  import plm_pkg::*;
  logic mclk, rst_n, wr, rd, alarm_condition, selfcheck_valid;
  logic run_stop_contact, mode_force_contact, mode_level_contact, remote_force_contact;
  logic mode_toggle_key, up_key, down_key, remote_toggle_key;
  logic actuator_open, actuator_close, alarm_out, pv_point_on, running;
  logic manual_operation, remote_setpoint_mode, comm_enable;
  logic [3:0]  addr, sc_fail, fault_tens, fault_ones;
  logic [15:0] wdata, rdata, measured_process_value, remote_setpoint_in;
  logic [15:0] pv_display, target_setpoint, close_cycles, n;
  logic [9:0]  control_out, heat_out, cool_out;
  logic [6:0]  sc_flags;
  logic [1:0]  pid_group;
  logic signed [10:0] auto_mv;
  plm_fault_type fault_kind;
  logic [6:0] flag_set [3] = '{7'h21, 7'h40, 7'h7f};
  logic [7:0] digits [3] = '{8'h33, 8'h64, 8'hc7};
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  int tog;
  logic p;

  plm_core #(.REPEAT_CYC(8), .BLINK_CYC(4)) dut_u (
    .mclk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
    .run_stop_contact, .mode_force_contact, .mode_level_contact, .remote_force_contact,
    .mode_toggle_key, .up_key, .down_key, .remote_toggle_key,
    .measured_process_value, .remote_setpoint_in, .auto_mv, .alarm_condition,
    .selfcheck_valid, .selfcheck_ram_fail(sc_fail[0]), .selfcheck_rom_fail(sc_fail[1]),
    .selfcheck_sys_fail(sc_fail[2]), .selfcheck_cal_fail(sc_fail[3]),
    .selfcheck_param_flags(sc_flags), .control_out, .heat_out, .cool_out,
    .actuator_open, .actuator_close, .alarm_out, .pv_display, .pv_point_on,
    .target_setpoint, .pid_group, .running, .manual_operation, .remote_setpoint_mode,
    .comm_enable, .fault_kind, .fault_tens, .fault_ones
  );
  plm_panel panel_u (
    .mclk, .actuator_close, .run_stop_contact, .mode_force_contact, .mode_level_contact,
    .remote_force_contact, .mode_toggle_key, .up_key, .down_key, .remote_toggle_key,
    .close_cycles
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // generous ceiling: the whole sequence needs about six hundred cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic do_reset();
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    wt(8);
  endtask
  // hold a key until exactly one step shows at the outputs
  task automatic step1(input int k);
    logic [29:0] s;
    int i;
    wt(3);
    s = {control_out, heat_out, cool_out};
    panel_u.hold(k, 1'b1);
    for (i = 0; i < 40 && {control_out, heat_out, cool_out} === s; i++) begin
      wt(1);
    end
    panel_u.hold(k, 1'b0);
    wt(10);
  endtask
  task automatic selfcheck(input logic [3:0] f, input logic [6:0] fl);
    do_reset();
    @(posedge mclk);
    sc_fail <= f;
    sc_flags <= fl;
    selfcheck_valid <= 1'b1;
    @(posedge mclk);
    selfcheck_valid <= 1'b0;
    wt(4);
  endtask

  initial begin
    rst_n = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    measured_process_value = 16'h0abc;
    remote_setpoint_in = 16'h0777;
    auto_mv = 11'sh064;
    alarm_condition = 1'b0;
    selfcheck_valid = 1'b0;
    sc_fail = 4'h0;
    sc_flags = 7'h00;
    do_reset();
    rchk(`PLM_REG_PRESET, 16'h0000);
    rchk(`PLM_REG_STEP, 16'h0001);
    wreg(4'hf, 16'hffff);
    rchk(4'hf, 16'h0000);
    wreg(`PLM_REG_PRESET, 16'h01f4);
    @(posedge mclk);
    alarm_condition <= 1'b1;
    wt(4);
    chk(control_out, 16'h01f4);
    chk({alarm_out, pv_display}, 17'h10abc);
    panel_u.press(0, 4);
    chk(manual_operation, 1'b1);
    step1(1);
    chk(control_out, 16'h01f4);
    panel_u.set_contacts(4'h1);
    chk(running, 1'b1);
    chk(control_out, 16'h0064);
    wreg(`PLM_REG_STEP, 16'h0005);
    step1(1);
    chk(control_out, 16'h0069);
    wreg(`PLM_REG_STEP, 16'h00ff);
    repeat (4) step1(1);
    chk(control_out, 16'h03e8);
    wreg(`PLM_REG_CTRL, 16'h0001);
    wreg(`PLM_REG_DEADBAND, 16'h007c);
    repeat (3) step1(2);
    chk({heat_out, cool_out}, {10'h0eb, 10'h000});
    step1(2);
    chk({heat_out, cool_out}, {10'h000, 10'h014});
    step1(1);
    chk({heat_out, cool_out}, {10'h0eb, 10'h000});
    wreg(`PLM_REG_DEADBAND, 16'h0784);
    wt(3);
    chk({heat_out, cool_out}, {10'h0eb, 10'h00d});
    step1(2);
    chk({heat_out, cool_out}, {10'h000, 10'h10c});
    wreg(`PLM_REG_CTRL, 16'h0002);
    n = close_cycles;
    panel_u.press(2, 20);
    chk(actuator_close, 1'b0);
    chk((close_cycles - n) inside {[16'd18:16'd22]}, 1'b1);
    panel_u.hold(1, 1'b1);
    wt(8);
    chk(actuator_open, 1'b1);
    panel_u.hold(1, 1'b0);
    wt(8);
    chk(actuator_open, 1'b0);
    wreg(4'h6, 16'h1234);
    wreg(`PLM_REG_CTRL, 16'h0020);
    panel_u.press(3, 4);
    chk({remote_setpoint_mode, target_setpoint}, 17'h01234);
    chk(pid_group, 2'h2);
    wreg(`PLM_REG_CTRL, 16'h0024);
    panel_u.press(3, 4);
    chk({remote_setpoint_mode, target_setpoint}, 17'h10777);
    chk(pid_group, 2'h2);
    panel_u.set_contacts(4'h9);
    panel_u.press(3, 4);
    chk(remote_setpoint_mode, 1'b1);
    panel_u.set_contacts(4'h3);
    chk(manual_operation, 1'b0);
    panel_u.press(0, 4);
    chk(manual_operation, 1'b0);
    rchk(`PLM_REG_STATUS, 16'h001b);
    @(posedge mclk);
    alarm_condition <= 1'b0;
    foreach (flag_set[i]) begin
      selfcheck(4'h0, flag_set[i]);
      chk({fault_kind == plm_fk_param, comm_enable, control_out}, 12'hc00);
      chk({fault_tens, fault_ones}, digits[i]);
    end
    selfcheck(4'h4, 7'h00);
    chk({fault_kind == plm_fk_sys, comm_enable, control_out}, 12'h800);
    rchk(`PLM_REG_DIAG, 16'h0500);
    selfcheck(4'h6, 7'h00);
    chk({fault_kind == plm_fk_sys, fault_ones}, 5'h11);
    selfcheck(4'h8, 7'h00);
    chk({fault_kind == plm_fk_none, comm_enable}, 2'h3);
    tog = 0;
    p = pv_point_on;
    repeat (20) begin
      wt(1);
      tog += (pv_point_on !== p) ? 1 : 0;
      p = pv_point_on;
    end
    chk(tog >= 3, 1'b1);
    end_of_test();
  end
endmodule
